// ===== pkg/sap_pkg.sv
// Constants and types shared by the serial audio port design files.
// Assumes a 20 MHz reference clock and an 8-bit register port with a
// 7-bit register address, decoded inside sap_audio_port.
//
// Summary of operation
// - Left-justified flips frame level against I2S
// - Left-justified MSB in first bit after change
// - PCM sync marks each frame, data left-justified
// - PCM sync pulse is one bit clock wide
// - PCM left MSB first or second bit
// - PCM dual frame: left word, then right
// - Companding only at 8 ksps, law selectable
// - Companded words use half the bits
// - Surplus output bits are driven zero
// - Control bit 0 selects PCM framing
// - Sample width 16, or 8 companded
// - Non-PCM accepts any word length
// - Short words: zero fill, truncate output
// - Long words: drop extra input, pad zeros
// - I2S MSB one bit after frame change

package sap_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [6:0] SAP_CTRL_ADDR = 7'h09;
  localparam logic [7:0] SAP_CTRL_RESET = 8'h00;
  localparam logic [7:0] SAP_CTRL_WMASK = 8'hFD;
  localparam logic [7:0] SAP_UNMAPPED_DATA = 8'hFF;
  localparam int SAP_CLOCK_MASTER_SELECT_BIT = 7;
  localparam int SAP_WL_BIT = 6;
  localparam int SAP_MONO_BIT = 5;
  localparam int SAP_DLY_BIT = 4;
  localparam int SAP_POL_BIT = 3;
  localparam int SAP_INV_BIT = 2;
  localparam int SAP_PCM_BIT = 0;

  // ---------------------------------------------------------------
  // Sample and word widths in bits
  // ---------------------------------------------------------------
  localparam int SAP_STD_WIDTH = 16;
  localparam int SAP_CMP_WIDTH = 8;
  localparam int SAP_STD_LONG = 32;
  localparam int SAP_CMP_LONG = 16;

  // ---------------------------------------------------------------
  // Master bit clock timing
  // ---------------------------------------------------------------
  localparam int SAP_REF_CLK_HZ = 20_000_000;
  localparam int SAP_BCLK_HZ = 2_000_000;
  localparam int SAP_BCLK_HALF_CYC = SAP_REF_CLK_HZ / (2 * SAP_BCLK_HZ);

  typedef enum logic [1:0] {RX_IDLE, RX_ARMED, RX_WORD} sap_rx_state_t;

endpackage

// ===== pkg/sap_word_if.sv
// Word hand-over bundle between the port logic and its clock crossing.
// Assumes the source holds src_data while src_valid is high.
`timescale 1ns/1ps

interface sap_word_if #(parameter int W = 16);
  logic src_valid;
  logic src_busy;
  logic [W-1:0] src_data;
  logic dst_valid;
  logic [W-1:0] dst_data;

  modport cdc (input src_valid, input src_data, output src_busy,
               output dst_valid, output dst_data);
  modport user (output src_valid, output src_data, input src_busy,
                input dst_valid, input dst_data);
endinterface

// ===== design/sap_word_cdc.sv
// Toggle handshake that carries one word between two clock domains.
// Assumes each domain has its own synchronous active-high reset.
`timescale 1ns/1ps

module sap_word_cdc #(parameter int W = 16)
(
  input wire logic src_clk,
  input wire logic src_rst,
  input wire logic dst_clk,
  input wire logic dst_rst,
  sap_word_if.cdc port
);
  import sap_pkg::*;

  logic req_q;
  logic ack_s1_q, ack_q;
  logic req_s1_q, req_s2_q, req_s3_q;
  logic [W-1:0] hold_q;
  logic valid_q;
  logic [W-1:0] data_q;

  if (W < 1)
  begin : g_bad_width
    $error("sap_word_cdc: width must be at least one");
  end

  // Hold stays still until the far side has acknowledged it
  assign port.src_busy = req_q != ack_q;

  always_ff @(posedge src_clk)
  begin
    if (src_rst)
    begin
      req_q <= 1'b0;
      hold_q <= '0;
    end
    else if (port.src_valid && !port.src_busy)
    begin
      req_q <= ~req_q;
      hold_q <= port.src_data;
    end
  end

  always_ff @(posedge src_clk)
  begin
    ack_s1_q <= req_s3_q;
    ack_q <= ack_s1_q;
  end

  always_ff @(posedge dst_clk)
  begin
    if (dst_rst)
    begin
      req_s1_q <= 1'b0;
      req_s2_q <= 1'b0;
      req_s3_q <= 1'b0;
      valid_q <= 1'b0;
      data_q <= '0;
    end
    else
    begin
      req_s1_q <= req_q;
      req_s2_q <= req_s1_q;
      req_s3_q <= req_s2_q;
      valid_q <= req_s2_q != req_s3_q;
      if (req_s2_q != req_s3_q)
      begin
        data_q <= hold_q;
      end
    end
  end

  assign port.dst_valid = valid_q;
  assign port.dst_data = data_q;
endmodule

// ===== design/sap_audio_port.sv
// Serial audio port: control register, master clock generation and the
// bit-clock side framer for I2S, left-justified and PCM formats.
// Assumes BCLK_I returns the pad level also while the port drives it.
`timescale 1ns/1ps

module sap_audio_port
#(
  parameter int BCLK_HALF_CYC = sap_pkg::SAP_BCLK_HALF_CYC
)
(
  input wire logic REF_CLK,
  input wire logic SRST,
  input wire logic [6:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [7:0] REG_RDATA,
  input wire logic AUDIO_PORT_ENABLE,
  input wire logic COMPAND_ENABLE,
  input wire logic COMPANDING_LAW_SELECT,
  input wire logic RATE_8K,
  output logic COMPAND_ACTIVE,
  output logic COMPAND_COMPANDING_LAW_SELECT,
  input wire logic BCLK_I,
  output logic BCLK_O,
  output logic BCLK_OE,
  input wire logic LRCLK_I,
  output logic LRCLK_O,
  output logic LRCLK_OE,
  input wire logic SDI,
  output logic SDO,
  input wire logic [15:0] TX_LEFT,
  input wire logic [15:0] TX_RIGHT,
  input wire logic TX_VALID,
  output logic TX_READY,
  output logic [15:0] RX_DATA,
  output logic RX_RIGHT,
  output logic RX_VALID
);
  import sap_pkg::*;

  if (BCLK_HALF_CYC < 1)
  begin : g_bad_div
    $error("sap_audio_port: bit clock half period below one cycle");
  end

  // ---------------------------------------------------------------
  // Control register and reference-domain state
  // ---------------------------------------------------------------
  logic [7:0] ctrl_q;
  logic en_q, rst_req_q, tx_pend_q;
  logic [31:0] tx_pair_q;
  logic [15:0] div_q;
  logic bclk_q;
  logic link_clk;

  sap_word_if #(.W(17)) rx_if ();
  sap_word_if #(.W(32)) tx_if ();

  always_ff @(posedge REF_CLK)
  begin
    if (SRST)
      ctrl_q <= SAP_CTRL_RESET;
    else if (REG_WR && REG_ADDR == SAP_CTRL_ADDR)
      ctrl_q <= REG_WDATA & SAP_CTRL_WMASK;
  end

  always_ff @(posedge REF_CLK)
  begin
    if (SRST)
      REG_RDATA <= 8'h00;
    else if (REG_RD)
      REG_RDATA <= (REG_ADDR == SAP_CTRL_ADDR) ? ctrl_q
                   : SAP_UNMAPPED_DATA;
  end

  // Companding settings are frozen while the port runs
  always_ff @(posedge REF_CLK)
  begin
    if (SRST)
    begin
      en_q <= 1'b0;
      rst_req_q <= 1'b1;
      COMPAND_ACTIVE <= 1'b0;
      COMPAND_COMPANDING_LAW_SELECT <= 1'b0;
    end
    else
    begin
      en_q <= AUDIO_PORT_ENABLE;
      rst_req_q <= !AUDIO_PORT_ENABLE;
      if (!en_q)
      begin
        COMPAND_ACTIVE <= COMPAND_ENABLE && RATE_8K;
        COMPAND_COMPANDING_LAW_SELECT <= COMPANDING_LAW_SELECT;
      end
    end
  end

  // Master bit clock from the reference clock
  always_ff @(posedge REF_CLK)
  begin
    if (SRST || !en_q || !ctrl_q[SAP_CLOCK_MASTER_SELECT_BIT])
    begin
      div_q <= 16'h0000;
      bclk_q <= 1'b0;
    end
    else if (div_q == 16'(BCLK_HALF_CYC - 1))
    begin
      div_q <= 16'h0000;
      bclk_q <= ~bclk_q;
    end
    else
      div_q <= div_q + 16'h0001;
  end

  always_ff @(posedge REF_CLK)
  begin
    if (SRST)
    begin
      BCLK_O <= 1'b0;
      BCLK_OE <= 1'b0;
      LRCLK_OE <= 1'b0;
    end
    else
    begin
      BCLK_O <= bclk_q;
      BCLK_OE <= en_q && ctrl_q[SAP_CLOCK_MASTER_SELECT_BIT];
      LRCLK_OE <= en_q && ctrl_q[SAP_CLOCK_MASTER_SELECT_BIT];
    end
  end

  // Transmit pair: one pair held, ready drops until the crossing takes it
  always_ff @(posedge REF_CLK)
  begin
    if (SRST)
    begin
      tx_pend_q <= 1'b0;
      tx_pair_q <= 32'h0000_0000;
      TX_READY <= 1'b0;
    end
    else if (tx_pend_q)
    begin
      if (!tx_if.src_busy)
      begin
        tx_pend_q <= 1'b0;
        TX_READY <= 1'b1;
      end
    end
    else if (TX_VALID && TX_READY)
    begin
      tx_pend_q <= 1'b1;
      tx_pair_q <= {TX_LEFT, TX_RIGHT};
      TX_READY <= 1'b0;
    end
    else
      TX_READY <= 1'b1;
  end

  assign tx_if.src_valid = tx_pend_q;
  assign tx_if.src_data = tx_pair_q;

  always_ff @(posedge REF_CLK)
  begin
    if (SRST)
    begin
      RX_DATA <= 16'h0000;
      RX_RIGHT <= 1'b0;
      RX_VALID <= 1'b0;
    end
    else
    begin
      RX_VALID <= rx_if.dst_valid;
      if (rx_if.dst_valid)
      begin
        RX_DATA <= rx_if.dst_data[15:0];
        RX_RIGHT <= rx_if.dst_data[16];
      end
    end
  end

  // ---------------------------------------------------------------
  // Link domain: reset, configuration and framing
  // ---------------------------------------------------------------
  // Edge swap by inverting the clock; the select follows every control write,
  // also while the port runs, so a runt edge can reach live logic.
  assign link_clk = BCLK_I ^ ctrl_q[SAP_INV_BIT];

  logic lrst_s1_q, lrst_q;
  logic [7:0] cfg_s1_q, cfg_q;
  logic clock_master_select, wl, mono, dly, frame_polarity, pcm, cmp, left_lvl, fs_act;
  logic [5:0] sw, slot, slot_len;
  logic [6:0] period;

  always_ff @(posedge link_clk)
  begin
    lrst_s1_q <= rst_req_q;
    lrst_q <= lrst_s1_q;
    cfg_s1_q <= {ctrl_q[7:2], ctrl_q[SAP_PCM_BIT], COMPAND_ACTIVE};
    cfg_q <= cfg_s1_q;
  end

  assign {clock_master_select, wl, mono, dly, frame_polarity} = cfg_q[7:3];
  assign pcm = cfg_q[1];
  assign cmp = cfg_q[0];
  assign sw = cmp ? 6'(SAP_CMP_WIDTH) : 6'(SAP_STD_WIDTH);
  assign slot = wl ? (cmp ? 6'(SAP_CMP_LONG) : 6'(SAP_STD_LONG))
                : sw;
  assign slot_len = clock_master_select ? slot : sw;
  assign period = (pcm && mono) ? {1'b0, slot} : {slot, 1'b0};
  // Left-justified uses the level opposite to I2S for the left word
  assign left_lvl = frame_polarity ^ (!pcm && !dly);
  assign fs_act = ~frame_polarity;

  // ---------------------------------------------------------------
  // Master frame clock, changes on the drive edge
  // ---------------------------------------------------------------
  logic [6:0] mcnt_q;
  logic pred_m;

  always_ff @(negedge link_clk)
  begin
    if (lrst_q || !clock_master_select)
    begin
      mcnt_q <= 7'h00;
      LRCLK_O <= 1'b0;
    end
    else
    begin
      mcnt_q <= (mcnt_q == period - 7'h01) ? 7'h00 : mcnt_q + 7'h01;
      if (pcm)
        LRCLK_O <= (mcnt_q == 7'h00) ? fs_act : ~fs_act;
      else
        LRCLK_O <= (mcnt_q < {1'b0, slot}) ? left_lvl : ~left_lvl;
    end
  end

  assign pred_m = (mcnt_q == 7'h00) || (!pcm && mcnt_q == {1'b0, slot});

  // ---------------------------------------------------------------
  // Receive framer on the latch edge
  // ---------------------------------------------------------------
  sap_rx_state_t st_q;
  logic fr_in, fr_q, start, chan_q, take, pub_q, pub_chan_q;
  logic [5:0] bcnt_q, scnt_q;
  logic [6:0] pcnt_q, flen_q;
  logic [15:0] rx_q, rx_ins, pub_data_q;

  assign fr_in = clock_master_select ? LRCLK_O : LRCLK_I;
  assign start = pcm ? (fr_in == fs_act && fr_q != fs_act)
                 : (fr_in != fr_q);
  assign take = (st_q == RX_WORD) && (bcnt_q < sw);

  // Bits past the sample width are dropped, missing ones stay zero
  always_comb
  begin
    rx_ins = rx_q;
    if (take)
      rx_ins[4'(15 - bcnt_q)] = SDI;
  end

  always_ff @(posedge link_clk)
  begin
    if (lrst_q)
    begin
      fr_q <= 1'b0;
      pcnt_q <= 7'h00;
      flen_q <= 7'h00;
    end
    else
    begin
      fr_q <= fr_in;
      pcnt_q <= start ? 7'h00 : pcnt_q + {6'h00, pcnt_q != 7'h7F};
      if (start)
        flen_q <= pcnt_q + 7'h01;
    end
  end

  always_ff @(posedge link_clk)
  begin
    if (lrst_q)
    begin
      st_q <= RX_IDLE;
      chan_q <= 1'b0;
      bcnt_q <= 6'h00;
      scnt_q <= 6'h00;
      rx_q <= 16'h0000;
      pub_q <= 1'b0;
      pub_chan_q <= 1'b0;
      pub_data_q <= 16'h0000;
    end
    else
    begin
      pub_q <= 1'b0;
      if (start)
      begin
        if (st_q == RX_WORD && !pcm)
        begin
          pub_q <= 1'b1;
          pub_chan_q <= chan_q;
          pub_data_q <= dly ? rx_ins : rx_q;
        end
        chan_q <= !pcm && (fr_in != left_lvl);
        if (!dly)
        begin
          st_q <= RX_WORD;
          rx_q <= {SDI, 15'h0000};
          bcnt_q <= 6'h01;
          scnt_q <= 6'h01;
        end
        else
        begin
          st_q <= RX_ARMED;
          rx_q <= 16'h0000;
        end
      end
      else if (st_q == RX_ARMED)
      begin
        st_q <= RX_WORD;
        rx_q <= {SDI, 15'h0000};
        bcnt_q <= 6'h01;
        scnt_q <= 6'h01;
      end
      else if (st_q == RX_WORD)
      begin
        rx_q <= rx_ins;
        bcnt_q <= bcnt_q + {5'h00, take};
        scnt_q <= scnt_q + 6'h01;
        if (pcm && scnt_q == slot_len - 6'h01)
        begin
          pub_q <= 1'b1;
          pub_chan_q <= chan_q;
          pub_data_q <= rx_ins;
          if (!chan_q && !mono)
          begin
            st_q <= RX_ARMED;
            chan_q <= 1'b1;
          end
          else
            st_q <= RX_IDLE;
        end
      end
    end
  end

  // Companded code goes out right-aligned in the 16-bit sample
  assign rx_if.src_valid = pub_q;
  assign rx_if.src_data = {pub_chan_q,
      cmp ? {8'h00, pub_data_q[15:8]} : pub_data_q};

  // ---------------------------------------------------------------
  // Transmit side on the drive edge
  // ---------------------------------------------------------------
  logic [31:0] tx_next_q;
  logic [15:0] tx_sh_q, tx_word;
  logic pred, msb_next, data_next, new_chan;

  always_ff @(posedge link_clk)
  begin
    if (lrst_q)
      tx_next_q <= 32'h0000_0000;
    else if (tx_if.dst_valid)
      tx_next_q <= tx_if.dst_data;
  end

  // A slave frame edge is predicted from the last measured period so
  // the first bit can leave a flip-flop; the first frame is lost.
  assign pred = clock_master_select ? pred_m : (pcnt_q + 7'h01 == flen_q);
  assign msb_next = (pred && !dly) || st_q == RX_ARMED;
  assign data_next = (st_q == RX_WORD) && (bcnt_q < sw);
  assign new_chan = (pred && !dly) ? (!pcm && (~fr_q != left_lvl))
                    : chan_q;
  assign tx_word = new_chan ? tx_next_q[15:0] : tx_next_q[31:16];

  always_ff @(negedge link_clk)
  begin
    if (lrst_q)
    begin
      SDO <= 1'b0;
      tx_sh_q <= 16'h0000;
    end
    else if (msb_next)
    begin
      SDO <= cmp ? tx_word[7] : tx_word[15];
      tx_sh_q <= cmp ? {tx_word[6:0], 9'h000} : {tx_word[14:0], 1'b0};
    end
    else if (data_next)
    begin
      SDO <= tx_sh_q[15];
      tx_sh_q <= {tx_sh_q[14:0], 1'b0};
    end
    else
      SDO <= 1'b0;
  end

  sap_word_cdc #(.W(17)) u_rx_cdc (
    .src_clk(link_clk),
    .src_rst(lrst_q),
    .dst_clk(REF_CLK),
    .dst_rst(SRST),
    .port(rx_if.cdc)
  );

  sap_word_cdc #(.W(32)) u_tx_cdc (
    .src_clk(REF_CLK),
    .src_rst(SRST),
    .dst_clk(link_clk),
    .dst_rst(lrst_q),
    .port(tx_if.cdc)
  );

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  sequence s_armed_word;
    st_q == RX_ARMED ##1 (st_q == RX_WORD && bcnt_q == 6'h01);
  endsequence

  a_ctrl_bit_one: assert property (@(posedge REF_CLK) disable iff (SRST)
    (REG_RD && REG_ADDR == SAP_CTRL_ADDR) |=> !REG_RDATA[1])
    else $error("control bit 1 read back as one");

  a_master_pins: assert property (@(posedge REF_CLK) disable iff (SRST)
    (en_q && ctrl_q[SAP_CLOCK_MASTER_SELECT_BIT]) |=> (BCLK_OE && LRCLK_OE))
    else $error("master role without clock pin drive");

  a_compand_rate: assert property (@(posedge REF_CLK) disable iff (SRST)
    $rose(COMPAND_ACTIVE) |-> $past(RATE_8K, 1) && !$past(en_q, 1))
    else $error("companding enabled off 8 ksps or while running");

  a_lj_msb_now: assert property (@(posedge link_clk) disable iff (lrst_q)
    (start && !dly) |=> (st_q == RX_WORD && bcnt_q == 6'h01))
    else $error("undelayed word did not take the MSB at once");

  a_i2s_msb_late: assert property (@(posedge link_clk) disable iff (lrst_q)
    (start && dly) |=> s_armed_word)
    else $error("delayed word MSB not on second edge");

  a_pcm_fs_width: assert property (@(posedge link_clk) disable iff (lrst_q)
    (clock_master_select && pcm && fr_in == fs_act) |=> fr_in != fs_act)
    else $error("frame sync wider than one bit clock");

  a_pcm_right_next: assert property (@(posedge link_clk) disable iff (lrst_q)
    (pcm && !mono && !start && st_q == RX_WORD && !chan_q
     && scnt_q == slot_len - 6'h01) |=> (chan_q and s_armed_word))
    else $error("right word did not follow the left word");

  a_width_cap: assert property (@(posedge link_clk) disable iff (lrst_q)
    st_q == RX_WORD |-> bcnt_q <= sw)
    else $error("more bits kept than the sample width");

  a_zero_fill: assert property (@(posedge link_clk) disable iff (lrst_q)
    (start && !dly) |=> rx_q[14:0] == 15'h0000)
    else $error("new word low bits not cleared");

  a_mono_left: assert property (@(posedge link_clk) disable iff (lrst_q)
    (pcm && mono && st_q == RX_WORD) |=> !(st_q == RX_ARMED && chan_q))
    else $error("mono frame armed a right word");

  a_surplus_zero: assert property (@(negedge link_clk) disable iff (lrst_q)
    (!msb_next && !data_next) |=> !SDO)
    else $error("surplus output bit not zero");
endmodule

// ===== verif/sap_host_model.sv
// Behavioural far-side audio host: makes bit and frame clocks, drives SDI
// and captures SDO. Assumes the audio port is a slave of this model.
`timescale 1ns/1ps

module sap_host_model
(
  input wire logic run,
  input wire logic inv,
  input wire logic pcm,
  input wire logic dly,
  input wire logic lvl,
  input wire logic [5:0] wlen,
  input wire logic [6:0] flen,
  input wire logic [31:0] l_word,
  input wire logic [31:0] r_word,
  input wire logic sdo,
  output logic bclk,
  output logic lrclk,
  output logic sdi,
  output logic [31:0] cap_l,
  output logic [31:0] cap_r
);
  logic raw, lr;
  int p, q;
  logic [31:0] sh_l, sh_r;

  // Clock pads are pulled up while the host is idle
  assign bclk = run ? raw ^ inv : 1'b1;
  assign lrclk = run ? lr : 1'b1;

  initial
  begin
    raw = 1'b1;
    lr = 1'b1;
    sdi = 1'b0;
    p = 0;
    forever
    begin
      #16;
      raw = 1'b0;
      if (!run)
        p = 0;
      q = p - dly;
      if (q < 0)
        q = q + flen;
      if (pcm)
        lr = (p == 0) ? lvl : ~lvl;
      else
        lr = (p < wlen) ? lvl : ~lvl;
      if (run && q < 2 * wlen)
        sdi = (q < wlen) ? l_word[31 - q] : r_word[31 + wlen - q];
      else
        sdi = ~sdi; // Released line must not hold the last bit
      #16;
      raw = 1'b1;
      if (q < wlen)
        sh_l[31 - q] = sdo;
      else if (q < 2 * wlen)
        sh_r[31 + wlen - q] = sdo;
      p = p + 1;
      if (p >= flen)
      begin
        p = 0;
        cap_l = sh_l;
        cap_r = sh_r;
        sh_l = '0;
        sh_r = '0;
      end
    end
  end
endmodule

// ===== verif/tb_top.sv
// Self-checking bench for the serial audio port in slave and master roles.
// Assumes the far-side host model and the design package are compiled.
`timescale 1ns/1ps

module tb_top;
  import sap_pkg::*;
  logic ref_clk, srst, reg_wr, reg_rd, en, cmp_en, law, rate;
  logic [6:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  logic cmp_act, cmp_companding_law_select, bclk_o, bclk_oe, lrclk_o, lrclk_oe, sdo;
  logic tx_ready, rx_right, rx_valid;
  logic [15:0] tx_l, tx_r, rx_data, rx_l, rx_r;
  logic run, inv, pcm, dly, lvl;
  logic [5:0] wlen;
  logic [6:0] flen;
  logic [31:0] l_word, r_word, cap_l, cap_r;
  wire h_bclk, h_lrclk, h_sdi, bclk, lrclk;
  logic rx_clr;
  int error_cnt, num_checks, test_n;

  // Pad levels: the driving party wins
  assign bclk = bclk_oe ? bclk_o : h_bclk;
  assign lrclk = lrclk_oe ? lrclk_o : h_lrclk;

  sap_audio_port #(.BCLK_HALF_CYC(1)) uut
  (
    .REF_CLK(ref_clk),
    .SRST(srst),
    .REG_ADDR(reg_addr),
    .REG_WDATA(reg_wdata),
    .REG_WR(reg_wr),
    .REG_RD(reg_rd),
    .REG_RDATA(reg_rdata),
    .AUDIO_PORT_ENABLE(en),
    .COMPAND_ENABLE(cmp_en),
    .COMPANDING_LAW_SELECT(law),
    .RATE_8K(rate),
    .COMPAND_ACTIVE(cmp_act),
    .COMPAND_COMPANDING_LAW_SELECT(cmp_companding_law_select),
    .BCLK_I(bclk),
    .BCLK_O(bclk_o),
    .BCLK_OE(bclk_oe),
    .LRCLK_I(lrclk),
    .LRCLK_O(lrclk_o),
    .LRCLK_OE(lrclk_oe),
    .SDI(h_sdi),
    .SDO(sdo),
    .TX_LEFT(tx_l),
    .TX_RIGHT(tx_r),
    .TX_VALID(1'b1),
    .TX_READY(tx_ready),
    .RX_DATA(rx_data),
    .RX_RIGHT(rx_right),
    .RX_VALID(rx_valid)
  );

  sap_host_model host
  (
    .run(run),
    .inv(inv),
    .pcm(pcm),
    .dly(dly),
    .lvl(lvl),
    .wlen(wlen),
    .flen(flen),
    .l_word(l_word),
    .r_word(r_word),
    .sdo(sdo),
    .bclk(h_bclk),
    .lrclk(h_lrclk),
    .sdi(h_sdi),
    .cap_l(cap_l),
    .cap_r(cap_r)
  );

  // ---------------------------------------------------------------
  // Clock, watchdog and received-word capture
  // ---------------------------------------------------------------
  initial
  begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  initial
  begin
    #1000000;
    error_cnt++;
    give_verdict();
  end

  // Words are cleared by each slave test so a stale one cannot pass
  always @(posedge ref_clk)
    if (rx_clr)
    begin
      rx_l <= 'x;
      rx_r <= 'x;
    end
    else if (rx_valid === 1'b1)
      if (rx_right)
        rx_r <= rx_data;
      else
        rx_l <= rx_data;

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  task wr(input logic [6:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge ref_clk);
    reg_wr = 1'b0;
  endtask

  task rd_chk(input string name, input logic [6:0] a, input logic [7:0] e);
    @(negedge ref_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge ref_clk);
    reg_rd = 1'b0;
    @(negedge ref_clk);
    chk(name, {24'h0, e}, {24'h0, reg_rdata});
  endtask

  // Word w bits, frame f bits, frame level lv, companding ce with law lw
  task slave(input logic [7:0] c, input int w, input int f, input logic lv,
             input logic ce, input logic lw);
    logic [31:0] m;
    int s;
    s = ce ? 8 : 16;
    m = ~(32'hFFFFFFFF >> w);
    @(negedge ref_clk);
    en = 1'b0;
    run = 1'b0;
    cmp_en = ce;
    law = lw;
    pcm = c[0];
    dly = c[4];
    inv = c[2];
    lvl = lv;
    wlen = 6'(w);
    flen = 7'(f);
    wr(SAP_CTRL_ADDR, c);
    rd_chk("control", SAP_CTRL_ADDR, c);
    run = 1'b1;
    repeat (60) @(negedge ref_clk);
    chk("compand active", {31'h0, ce}, {31'h0, cmp_act});
    chk("compand law", {31'h0, lw}, {31'h0, cmp_companding_law_select});
    en = 1'b1;
    repeat (200) @(negedge ref_clk);
    rx_clr = 1'b1;
    @(negedge ref_clk);
    rx_clr = 1'b0;
    repeat (200) @(negedge ref_clk);
    chk("rx left", (l_word & m) >> (32 - s),
        {16'h0, rx_l});
    chk("rx right", (r_word & m) >> (32 - s),
        {16'h0, rx_r});
    chk("tx left", (32'(ce ? tx_l[7:0] : tx_l) << (32 - s)) & m,
        cap_l);
    chk("tx right", (32'(ce ? tx_r[7:0] : tx_r) << (32 - s)) & m,
        cap_r);
    test_n++;
    $display("test %0d done", test_n);
  endtask

  // Master role: c is the control byte, e the bits of one high frame level
  task master(input logic [7:0] c, input int e);
    int k;
    @(negedge ref_clk);
    en = 1'b0;
    // Host clock runs while disabled so the link logic sees its reset
    run = 1'b1;
    cmp_en = 1'b1;
    rate = 1'b0;
    repeat (60) @(negedge ref_clk);
    chk("compand off rate", 32'h0, {31'h0, cmp_act});
    run = 1'b0;
    wr(SAP_CTRL_ADDR, c);
    en = 1'b1;
    repeat (40) @(negedge ref_clk);
    chk("clock drive", 32'h1, {31'h0, bclk_oe});
    // Leave the high level, pass the low one, then count the next high
    for (int j = 0; j < 3; j++)
    begin
      k = 0;
      while (lrclk_o === (j != 1) && k < 200)
      begin
        @(posedge bclk_o);
        k++;
      end
    end
    chk("master high bits", 32'(e), 32'(k));
    @(negedge ref_clk);
    en = 1'b0;
    repeat (20) @(negedge ref_clk);
    chk("clock release", 32'h0, {31'h0, bclk_oe});
    test_n++;
    $display("test %0d done", test_n);
  endtask

  task give_verdict();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial
  begin
    srst = 1'b1;
    {reg_wr, reg_rd, en, cmp_en, law, rate} = 6'h01;
    reg_addr = 7'h00;
    reg_wdata = 8'h00;
    {run, inv, pcm, dly, lvl} = 5'h00;
    wlen = 6'd16;
    flen = 7'd32;
    l_word = 32'hA5C396E1;
    r_word = 32'h5A3C1F87;
    tx_l = 16'hB2D4;
    tx_r = 16'h4E71;
    rx_clr = 1'b0;
    repeat (8) @(negedge ref_clk);
    srst = 1'b0;
    rd_chk("control reset", SAP_CTRL_ADDR, 8'h00);
    wr(SAP_CTRL_ADDR, 8'hFF);
    rd_chk("unused bit", SAP_CTRL_ADDR, 8'hFD);
    rd_chk("unmapped", 7'h7F, 8'hFF);
    slave(8'h10, 16, 32, 1'b0, 1'b0, 1'b0);
    slave(8'h00, 24, 48, 1'b1, 1'b0, 1'b0);
    slave(8'h08, 12, 24, 1'b0, 1'b0, 1'b0);
    slave(8'h01, 16, 34, 1'b1, 1'b0, 1'b0);
    slave(8'h1D, 16, 36, 1'b0, 1'b0, 1'b0);
    slave(8'h10, 16, 32, 1'b0, 1'b1, 1'b1);
    master(8'hC0, 32);
    master(8'h81, 1);
    master(8'hA1, 1);
    give_verdict();
  end
endmodule
